// ==== rtl/global_config_defines.svh ====
`ifndef GLOBAL_CONFIG_DEFINES_SVH
`define GLOBAL_CONFIG_DEFINES_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define GCFG_OFFSET 8'h00
`define GCFG_RESET 8'h00
`define GCFG_ADDR_W 8
`define GCFG_DATA_W 8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define GCFG_DEBUG_DIS_BIT 0
`define GCFG_ACT_LEVEL_BIT 1
`define GCFG_WRITE_MASK 8'h03

`endif

// ==== rtl/global_config_pkg.sv ====
`include "global_config_defines.svh"

package global_config_pkg;

  // Which way a return from interrupt goes
  typedef enum logic [0:0] {
    ACT_MAIN = 1'b0,
    ACT_INT_ONLY = 1'b1
  } activation_level_t;

  // Sleep-control state after a return from interrupt
  typedef enum logic [1:0] {
    SLP_RUN = 2'b00,
    SLP_WAIT = 2'b01,
    SLP_HALT = 2'b10
  } sleep_state_t;

endpackage : global_config_pkg

// ==== rtl/return_ctrl.sv ====
`timescale 1ns/10ps
`include "global_config_defines.svh"

module return_ctrl
  import global_config_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic actLevel,
  input wire logic enterWait,
  input wire logic enterHalt,
  input wire logic returnFromInterrupt,
  output logic restoreContext,
  output logic sleepReturn,
  output sleep_state_t sleepState
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic restore;
    logic toSleep;
    sleep_state_t last;
  } ret_t;

  ret_t cur_r;
  ret_t cur_nxt;

  // Decode a return from interrupt against the level bit
  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.restore = 1'b0;
    cur_nxt.toSleep = 1'b0;
    // Remember which low-power state was entered last
    if (enterHalt) begin
      cur_nxt.last = SLP_HALT;
    end else if (enterWait) begin
      cur_nxt.last = SLP_WAIT;
    end
    if (returnFromInterrupt) begin
      if (actLevel == ACT_INT_ONLY) begin
        // Straight back to sleep, context stays on the stack
        cur_nxt.toSleep = 1'b1;
      end else begin
        // Pop context, resume main program after the wait
        cur_nxt.restore = 1'b1;
        cur_nxt.last = SLP_RUN;
      end
    end
  end

  // Register the state
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cur_r <= '{restore: 1'b0, toSleep: 1'b0, last: SLP_RUN};
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign restoreContext = cur_r.restore;
  assign sleepReturn = cur_r.toSleep;
  assign sleepState = cur_r.last;

endmodule : return_ctrl

// ==== rtl/global_config.sv ====
`timescale 1ns/10ps
`include "global_config_defines.svh"

module global_config
  import global_config_pkg::*;
#(
  parameter int ADDR_W = `GCFG_ADDR_W
)(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic gpioOut,
  input wire logic gpioOutEn,
  input wire logic debugOut,
  input wire logic debugOutEn,
  input wire logic pinIn,
  output logic pinOut,
  output logic pinOutEn,
  output logic debugIn,
  output logic gpioIn,
  output logic singleWireDebugEn,
  input wire logic enterWait,
  input wire logic enterHalt,
  input wire logic returnFromInterrupt,
  output logic restoreContext,
  output logic sleepReturn,
  output sleep_state_t sleepState
);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_width
    $error("ADDR_W out of range");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic debugDisable; // Bit 0
    activation_level_t actLevel; // Bit 1
    logic [7:0] rdata; // Read data
  } cfg_t;

  cfg_t cfg_r;
  cfg_t cfg_nxt;

  logic hit; // Register selected

  assign hit = (regAddr == ADDR_W'(`GCFG_OFFSET));

  // Register write and read path
  always_comb begin
    cfg_nxt = cfg_r;
    if (hit && regWrite) begin
      // Only the two defined bits store; the rest drop
      cfg_nxt.debugDisable = regWdata[`GCFG_DEBUG_DIS_BIT];
      cfg_nxt.actLevel = activation_level_t'(regWdata[`GCFG_ACT_LEVEL_BIT]);
    end
    if (hit && regRead) begin
      // Upper bits read as zero
      cfg_nxt.rdata = 8'h00;
      cfg_nxt.rdata[`GCFG_DEBUG_DIS_BIT] = cfg_r.debugDisable;
      cfg_nxt.rdata[`GCFG_ACT_LEVEL_BIT] = cfg_r.actLevel;
    end else if (regRead) begin
      // Unmapped address reads zero
      cfg_nxt.rdata = 8'h00;
    end
  end

  // Register update; reset clears, so debug mode is on
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r <= '{debugDisable: 1'b0, actLevel: ACT_MAIN, rdata: `GCFG_RESET};
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  assign regRdata = cfg_r.rdata;

  // ----------------------------------------
  // Pin ownership
  // ----------------------------------------
  // GPIO only gets the pin once debug is disabled
  assign singleWireDebugEn = ~cfg_r.debugDisable;
  assign pinOut = cfg_r.debugDisable ? gpioOut : debugOut;
  assign pinOutEn = cfg_r.debugDisable ? gpioOutEn : debugOutEn;
  assign debugIn = cfg_r.debugDisable ? 1'b1 : pinIn;
  assign gpioIn = cfg_r.debugDisable ? pinIn : 1'b0;

  // ----------------------------------------
  // Return-from-interrupt behaviour
  // ----------------------------------------
  return_ctrl u_ret (
    .mclk(mclk),
    .reset_n(reset_n),
    .actLevel(cfg_r.actLevel),
    .enterWait(enterWait),
    .enterHalt(enterHalt),
    .returnFromInterrupt(returnFromInterrupt),
    .restoreContext(restoreContext),
    .sleepReturn(sleepReturn),
    .sleepState(sleepState)
  );

endmodule : global_config

// ==== tb/global_config_chk.sv ====
`timescale 1ns/10ps
module global_config_chk (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic gpioIn,
  input wire logic singleWireDebugEn,
  input wire logic returnFromInterrupt,
  input wire logic restoreContext,
  input wire logic sleepReturn,
  input wire logic enterHalt,
  input wire logic [1:0] sleepState
);
  logic lvl_r; // Shadow of the level bit
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) lvl_r <= 1'b0;
    else if (regWrite && regAddr == 8'h00) lvl_r <= regWdata[1];
  end
  sequence cfgWr;
    regWrite && regAddr == 8'h00;
  endsequence
  chk_rst_debug: assert property ($rose(reset_n) |-> singleWireDebugEn)
    else $error("debug off at reset");
  chk_wr_release: assert property (cfgWr ##0 regWdata[0] |=> !singleWireDebugEn)
    else $error("pin not released");
  chk_debug_gpio: assert property (singleWireDebugEn |-> !gpioIn)
    else $error("gpio seen in debug");
  chk_level_read: assert property (regRead && regAddr == 8'h00
    |=> regRdata[1] == $past(lvl_r)) else $error("level bit wrong");
  chk_ret_main: assert property (returnFromInterrupt && !lvl_r
    |=> restoreContext && !sleepReturn) else $error("no restore");
  chk_ret_sleep: assert property (returnFromInterrupt && lvl_r
    |=> sleepReturn && !restoreContext ##1 !sleepReturn) else $error("no sleep");
  chk_rsvd_zero: assert property (regRead |=> regRdata[7:2] == 6'h00)
    else $error("reserved bits set");
  chk_halt_kept: assert property (enterHalt && !returnFromInterrupt |=> sleepState == 2'b10)
    else $error("halt state not kept");
endmodule : global_config_chk

// ==== tb/global_config_test.sv ====
`timescale 1ns/10ps
module global_config_test;
  logic mclk = 0, reset_n = 0, regWrite = 0, regRead = 0, gpioOut = 1, pinIn = 1;
  logic returnFromInterrupt = 0, pinOut, gpioIn, singleWireDebugEn, restoreContext, sleepReturn;
  logic [7:0] regAddr = 0, regWdata = 0, regRdata;
  logic enterWait = 0, enterHalt = 0, pinOutEn, debugIn;
  logic [1:0] sleepState;
  int errors = 0, tests_run = 0;
  always #2 mclk = ~mclk;
  global_config u_dut (.mclk, .reset_n, .regAddr, .regWrite, .regRead, .regWdata, .regRdata,
    .gpioOut, .gpioOutEn(1'b1), .debugOut(1'b0), .debugOutEn(1'b0), .pinIn, .pinOut,
    .pinOutEn, .debugIn, .gpioIn, .singleWireDebugEn, .enterWait, .enterHalt,
    .returnFromInterrupt, .restoreContext, .sleepReturn, .sleepState);
  task chk(input logic [7:0] g, e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("mismatch %0t %h %h", $time, g, e);
    end
  endtask : chk
  // One register access, write or read
  task acc(input logic w, input logic [7:0] a, d);
    @(negedge mclk);
    {regWrite, regRead, regAddr, regWdata} = {w, !w, a, d};
    @(negedge mclk);
    {regWrite, regRead} = 2'b00;
  endtask : acc
  task ret();
    returnFromInterrupt = 1;
    @(negedge mclk);
    returnFromInterrupt = 0;
  endtask : ret
  task test_reset();
    acc(0, 8'h00, 8'h00);
    chk(regRdata, 8'h00);
    chk(singleWireDebugEn, 1);
    chk(gpioIn, 0);
    chk({pinOutEn, debugIn, pinOut}, 3'b010);
  endtask : test_reset
  task test_release();
    acc(1, 8'h00, 8'hfd);
    acc(1, 8'h05, 8'h00);
    acc(0, 8'h00, 8'h00);
    chk(regRdata, 8'h01);
    chk({singleWireDebugEn, pinOut, gpioIn}, 3'b011);
    chk({pinOutEn, debugIn}, 2'b11);
    acc(0, 8'h05, 8'h00);
    chk(regRdata, 8'h00);
  endtask : test_release
  task test_level();
    ret();
    chk({restoreContext, sleepReturn}, 2'b10);
    acc(1, 8'h00, 8'h02);
    ret();
    chk({restoreContext, sleepReturn, singleWireDebugEn}, 3'b011);
    acc(0, 8'h00, 8'h00);
    chk(regRdata, 8'h02);
  endtask : test_level
  // Last sleep state kept on an interrupt-only return, cleared on a main return
  task test_sleep();
    enterHalt = 1;
    @(negedge mclk);
    enterHalt = 0;
    chk(sleepState, 8'h02);
    ret();
    chk({sleepReturn, sleepState}, 3'b110);
    enterWait = 1;
    @(negedge mclk);
    enterWait = 0;
    chk(sleepState, 8'h01);
    acc(1, 8'h00, 8'h00);
    ret();
    chk({restoreContext, sleepState}, 3'b100);
  endtask : test_sleep
  task report_and_stop();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (5) @(negedge mclk);
    reset_n = 1;
    test_reset();
    test_release();
    test_level();
    test_sleep();
    report_and_stop();
  end
endmodule : global_config_test
bind global_config global_config_chk u_chk (.mclk, .reset_n, .regAddr, .regWrite, .regRead,
  .regWdata, .regRdata, .gpioIn, .singleWireDebugEn, .returnFromInterrupt, .restoreContext,
  .sleepReturn, .enterHalt, .sleepState);
